// File: rtl/bbc_regs.vh
// register offsets, reset values and field positions of the baseband config bank
`ifndef BBC_REGS_VH
`define BBC_REGS_VH

`define BBC_ADDR_W          8
`define BBC_IDX_LSB         2
`define BBC_NUM_REGS        32

`define BBC_OFF_PART_ID     8'h00
`define BBC_OFF_IO_POL      8'h04
`define BBC_OFF_TXRX_CTRL   8'h08
`define BBC_OFF_CAL_POS     8'h0c
`define BBC_OFF_CAL_NEG     8'h10
`define BBC_OFF_CCA_ANT     8'h14
`define BBC_OFF_PREAMBLE    8'h18
`define BBC_OFF_SCRAM_TAPS  8'h1c
`define BBC_OFF_SQ1_HI      8'h20
`define BBC_OFF_SQ1_LO      8'h24
`define BBC_OFF_SQ2_HI      8'h28
`define BBC_OFF_SQ2_LO      8'h2c
`define BBC_OFF_CCA_HI      8'h30
`define BBC_OFF_CCA_LO      8'h34
`define BBC_OFF_ED_THRESH   8'h38
`define BBC_OFF_SFD_TIMER   8'h3c
`define BBC_OFF_SF_BKR_BIN  8'h40
`define BBC_OFF_SF_BKR_QUAD 8'h44
`define BBC_OFF_SF_WAL_BIN  8'h48
`define BBC_OFF_SF_WAL_QUAD 8'h4c
`define BBC_OFF_TX_SIG_SEL  8'h50
`define BBC_OFF_TX_SERVICE  8'h54
`define BBC_OFF_TX_LEN_HI   8'h58
`define BBC_OFF_TX_LEN_LO   8'h5c
`define BBC_OFF_RX_STATUS   8'h60
`define BBC_OFF_RX_SERVICE  8'h64
`define BBC_OFF_RX_LEN_HI   8'h68
`define BBC_OFF_RX_LEN_LO   8'h6c
`define BBC_OFF_TBUS_SEL    8'h70
`define BBC_OFF_TBUS_OBS    8'h74
`define BBC_OFF_TEST1       8'h78
`define BBC_OFF_TEST2       8'h7c

`define BBC_RST_IO_POL      8'h00
`define BBC_RST_TXRX_CTRL   8'h14
`define BBC_RST_CAL_POS     8'h02
`define BBC_RST_CAL_NEG     8'hff
`define BBC_RST_CCA_ANT     8'h04
`define BBC_RST_PREAMBLE    8'h80
`define BBC_RST_SCRAM_TAPS  8'h48
`define BBC_RST_SQ1_HI      8'h01
`define BBC_RST_SQ1_LO      8'h88
`define BBC_RST_SQ2_HI      8'h00
`define BBC_RST_SQ2_LO      8'h98
`define BBC_RST_CCA_HI      8'h01
`define BBC_RST_CCA_LO      8'h98
`define BBC_RST_ED_THRESH   8'h20
`define BBC_RST_SFD_TIMER   8'h90
`define BBC_RST_SF_BKR_BIN  8'h0a
`define BBC_RST_SF_BKR_QUAD 8'h14
`define BBC_RST_SF_WAL_BIN  8'h37
`define BBC_RST_SF_WAL_QUAD 8'h6e
`define BBC_RST_TX_SIG_SEL  8'h00
`define BBC_RST_TX_SERVICE  8'h00
`define BBC_RST_TX_LEN_HI   8'hff
`define BBC_RST_TX_LEN_LO   8'hff
`define BBC_RST_TBUS_SEL    8'h00
`define BBC_RST_TEST1       8'h00
`define BBC_RST_TEST2       8'h02

`define BBC_POL_TX_EN_BIT   2

`endif

// File: rtl/bbc_acq_corr.v
// acquisition matched-filter correlator on raw, uncorrected sign samples
`timescale 1ns/1ps
module bbc_acq_corr #(
  parameter CHIPS = 11,
  parameter CNT_W = 4,
  parameter [CHIPS-1:0] CODE = 11'h5b8
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             sample_valid,
  input  wire             sample_sign,
  output reg  [CNT_W-1:0] match_q
);

  localparam STAGES = 2 * CHIPS;

  reg [STAGES-1:0] shift_q;
  reg [CNT_W-1:0]  match_d;
  integer          k;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= {STAGES{1'b0}};
    end else if (sample_valid) begin
      shift_q <= {shift_q[STAGES-2:0], sample_sign};
    end
  end

  always @* begin
    match_d = {CNT_W{1'b0}};
    for (k = 0; k < CHIPS; k = k + 1) begin
      if (shift_q[2*k] == CODE[k]) begin
        match_d = match_d + 1'b1;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= {CNT_W{1'b0}};
    end else begin
      match_q <= match_d;
    end
  end

endmodule // bbc_acq_corr

// File: rtl/bbc_rx_hdr_capture.v
// holds the received header fields reported by the demodulator
`timescale 1ns/1ps
module bbc_rx_hdr_capture (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       hdr_valid,
  input  wire [7:0] hdr_status,
  input  wire [7:0] hdr_service,
  input  wire [7:0] hdr_len_high,
  input  wire [7:0] hdr_len_low,
  output reg  [7:0] status_q,
  output reg  [7:0] service_q,
  output reg  [7:0] len_high_q,
  output reg  [7:0] len_low_q
);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q   <= 8'h00;
      service_q  <= 8'h00;
      len_high_q <= 8'h00;
      len_low_q  <= 8'h00;
    end else if (hdr_valid) begin
      status_q   <= hdr_status;
      service_q  <= hdr_service;
      len_high_q <= hdr_len_high;
      len_low_q  <= hdr_len_low;
    end
  end

endmodule // bbc_rx_hdr_capture

// File: rtl/bbc_regs_top.v
// APB register bank of the baseband processor with transmit setup outputs
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "bbc_regs.vh"

////////////////////////////////////////////////////////////////////////////
module bbc_regs_top #(
  parameter [7:0] PART_VERSION = 8'h5a,
  parameter       CORR_CHIPS   = 11
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        transmit_enable_input,
  input  wire        receive_enable_input,
  input  wire        rx_hdr_valid,
  input  wire [7:0]  rx_hdr_status,
  input  wire [7:0]  rx_hdr_service,
  input  wire [7:0]  rx_hdr_len_high,
  input  wire [7:0]  rx_hdr_len_low,
  input  wire [7:0]  test_bus_observe_in,
  input  wire        acq_sample_valid,
  input  wire        acq_sample_sign,
  output wire [3:0]  acq_match_count,
  output reg         tx_active,
  output reg         rx_active,
  output reg  [1:0]  tx_mod_sel,
  output reg         tx_mod_sel_valid,
  output reg  [7:0]  tx_signal_code,
  output reg  [7:0]  tx_service,
  output reg  [15:0] tx_length,
  output reg  [7:0]  io_polarity,
  output reg  [7:0]  tx_rx_control,
  output reg  [7:0]  scrambler_taps,
  output reg  [7:0]  preamble_length,
  output reg  [7:0]  sfd_timer,
  output reg  [7:0]  test_bus_select
);

  ////////////////////////////////////////////////////////////////////////
  // register index helpers

  localparam IDX_W = 6;

  // six-bit register number from the byte address
  function [IDX_W-1:0] reg_index;
    input [7:0] addr;
    begin
      reg_index = addr[7:`BBC_IDX_LSB];
    end
  endfunction

  localparam [IDX_W-1:0] I_PART_ID   = reg_index(`BBC_OFF_PART_ID);
  localparam [IDX_W-1:0] I_IO_POL    = reg_index(`BBC_OFF_IO_POL);
  localparam [IDX_W-1:0] I_TXRX      = reg_index(`BBC_OFF_TXRX_CTRL);
  localparam [IDX_W-1:0] I_SCRAM     = reg_index(`BBC_OFF_SCRAM_TAPS);
  localparam [IDX_W-1:0] I_PREAMBLE  = reg_index(`BBC_OFF_PREAMBLE);
  localparam [IDX_W-1:0] I_SFD       = reg_index(`BBC_OFF_SFD_TIMER);
  localparam [IDX_W-1:0] I_SF_BASE   = reg_index(`BBC_OFF_SF_BKR_BIN);
  localparam [IDX_W-1:0] I_SIG_SEL   = reg_index(`BBC_OFF_TX_SIG_SEL);
  localparam [IDX_W-1:0] I_SERVICE   = reg_index(`BBC_OFF_TX_SERVICE);
  localparam [IDX_W-1:0] I_LEN_HI    = reg_index(`BBC_OFF_TX_LEN_HI);
  localparam [IDX_W-1:0] I_LEN_LO    = reg_index(`BBC_OFF_TX_LEN_LO);
  localparam [IDX_W-1:0] I_RX_STAT   = reg_index(`BBC_OFF_RX_STATUS);
  localparam [IDX_W-1:0] I_RX_SERV   = reg_index(`BBC_OFF_RX_SERVICE);
  localparam [IDX_W-1:0] I_RX_LEN_HI = reg_index(`BBC_OFF_RX_LEN_HI);
  localparam [IDX_W-1:0] I_RX_LEN_LO = reg_index(`BBC_OFF_RX_LEN_LO);
  localparam [IDX_W-1:0] I_TBUS_SEL  = reg_index(`BBC_OFF_TBUS_SEL);
  localparam [IDX_W-1:0] I_TBUS_OBS  = reg_index(`BBC_OFF_TBUS_OBS);

  // registers that only the device writes
  function is_read_only;
    input [IDX_W-1:0] idx;
    begin
      is_read_only = (idx == I_PART_ID) || (idx == I_RX_STAT) ||
                     (idx == I_RX_SERV) || (idx == I_RX_LEN_HI) ||
                     (idx == I_RX_LEN_LO) || (idx == I_TBUS_OBS);
    end
  endfunction

  function is_mapped;
    input [IDX_W-1:0] idx;
    begin
      is_mapped = (idx < `BBC_NUM_REGS);
    end
  endfunction

  // reset values, including the default signal-field codes
  function [7:0] reset_value;
    input [IDX_W-1:0] idx;
    begin
      case ({idx, 2'b00})
        `BBC_OFF_IO_POL:      reset_value = `BBC_RST_IO_POL;
        `BBC_OFF_TXRX_CTRL:   reset_value = `BBC_RST_TXRX_CTRL;
        `BBC_OFF_CAL_POS:     reset_value = `BBC_RST_CAL_POS;
        `BBC_OFF_CAL_NEG:     reset_value = `BBC_RST_CAL_NEG;
        `BBC_OFF_CCA_ANT:     reset_value = `BBC_RST_CCA_ANT;
        `BBC_OFF_PREAMBLE:    reset_value = `BBC_RST_PREAMBLE;
        `BBC_OFF_SCRAM_TAPS:  reset_value = `BBC_RST_SCRAM_TAPS;
        `BBC_OFF_SQ1_HI:      reset_value = `BBC_RST_SQ1_HI;
        `BBC_OFF_SQ1_LO:      reset_value = `BBC_RST_SQ1_LO;
        `BBC_OFF_SQ2_HI:      reset_value = `BBC_RST_SQ2_HI;
        `BBC_OFF_SQ2_LO:      reset_value = `BBC_RST_SQ2_LO;
        `BBC_OFF_CCA_HI:      reset_value = `BBC_RST_CCA_HI;
        `BBC_OFF_CCA_LO:      reset_value = `BBC_RST_CCA_LO;
        `BBC_OFF_ED_THRESH:   reset_value = `BBC_RST_ED_THRESH;
        `BBC_OFF_SFD_TIMER:   reset_value = `BBC_RST_SFD_TIMER;
        `BBC_OFF_SF_BKR_BIN:  reset_value = `BBC_RST_SF_BKR_BIN;
        `BBC_OFF_SF_BKR_QUAD: reset_value = `BBC_RST_SF_BKR_QUAD;
        `BBC_OFF_SF_WAL_BIN:  reset_value = `BBC_RST_SF_WAL_BIN;
        `BBC_OFF_SF_WAL_QUAD: reset_value = `BBC_RST_SF_WAL_QUAD;
        `BBC_OFF_TX_SIG_SEL:  reset_value = `BBC_RST_TX_SIG_SEL;
        `BBC_OFF_TX_SERVICE:  reset_value = `BBC_RST_TX_SERVICE;
        `BBC_OFF_TX_LEN_HI:   reset_value = `BBC_RST_TX_LEN_HI;
        `BBC_OFF_TX_LEN_LO:   reset_value = `BBC_RST_TX_LEN_LO;
        `BBC_OFF_TBUS_SEL:    reset_value = `BBC_RST_TBUS_SEL;
        `BBC_OFF_TEST1:       reset_value = `BBC_RST_TEST1;
        `BBC_OFF_TEST2:       reset_value = `BBC_RST_TEST2;
        default:              reset_value = 8'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  wire [IDX_W-1:0] bus_idx;
  wire             setup_phase;
  wire             access_phase;
  wire             link_busy;
  wire             ctrl_locked;
  wire             wr_ok;

  assign bus_idx      = reg_index(paddr);
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;

  // transmit/receive setup refused while either enable is active
  assign link_busy   = tx_active | rx_active;
  assign ctrl_locked = link_busy & (bus_idx == I_TXRX);

  assign wr_ok = access_phase & pwrite & is_mapped(bus_idx) &
                 ~is_read_only(bus_idx) & ~ctrl_locked;

  // zero wait states: read data was prepared in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = access_phase &
                   (~is_mapped(bus_idx) | (pwrite & ctrl_locked));

  ////////////////////////////////////////////////////////////////////////
  // storage

  reg [7:0] regs_q [0:`BBC_NUM_REGS-1];

  wire [7:0] rx_status_v;
  wire [7:0] rx_service_v;
  wire [7:0] rx_len_high_v;
  wire [7:0] rx_len_low_v;

  integer i;

  // transmit length bytes held as plain writable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < `BBC_NUM_REGS; i = i + 1) begin
        regs_q[i] <= reset_value(i[IDX_W-1:0]);
      end
    end else if (wr_ok) begin
      regs_q[bus_idx[4:0]] <= pwdata[7:0];
    end
  end

  // received header fields from the demodulator
  bbc_rx_hdr_capture u_rx_hdr (
    .pclk         (pclk),
    .presetn      (presetn),
    .hdr_valid    (rx_hdr_valid),
    .hdr_status   (rx_hdr_status),
    .hdr_service  (rx_hdr_service),
    .hdr_len_high (rx_hdr_len_high),
    .hdr_len_low  (rx_hdr_len_low),
    .status_q     (rx_status_v),
    .service_q    (rx_service_v),
    .len_high_q   (rx_len_high_v),
    .len_low_q    (rx_len_low_v)
  );

  ////////////////////////////////////////////////////////////////////////
  // read path

  reg [7:0] rd_val;

  // writable registers read back their stored value
  // read-only registers show the part version, the captured header fields or the live test bus
  always @* begin
    case (bus_idx)
      I_PART_ID:   rd_val = PART_VERSION;
      I_RX_STAT:   rd_val = rx_status_v;
      I_RX_SERV:   rd_val = rx_service_v;
      I_RX_LEN_HI: rd_val = rx_len_high_v;
      I_RX_LEN_LO: rd_val = rx_len_low_v;
      I_TBUS_OBS:  rd_val = test_bus_observe_in;
      default: begin
        if (is_mapped(bus_idx)) begin
          rd_val = regs_q[bus_idx[4:0]];
        end else begin
          rd_val = 8'h00;
        end
      end
    endcase
  end

  // captured in the setup cycle so prdata comes from a flip-flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_phase & ~pwrite) begin
      prdata <= {24'h000000, rd_val};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit setup outputs

  wire [1:0] sel_code;
  wire       sel_legal;

  assign sel_code  = regs_q[I_SIG_SEL[4:0]][1:0];
  assign sel_legal = (regs_q[I_SIG_SEL[4:0]][7:2] == 6'h00);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_active        <= 1'b0;
      rx_active        <= 1'b0;
      tx_mod_sel       <= 2'h0;
      tx_mod_sel_valid <= 1'b0;
      tx_signal_code   <= 8'h00;
      tx_service       <= 8'h00;
      tx_length        <= 16'h0000;
      io_polarity      <= 8'h00;
      tx_rx_control    <= 8'h00;
      scrambler_taps   <= 8'h00;
      preamble_length  <= 8'h00;
      sfd_timer        <= 8'h00;
      test_bus_select  <= 8'h00;
    end else begin
      // transmit enable level follows the polarity setting
      tx_active <= transmit_enable_input ^
                   regs_q[I_IO_POL[4:0]][`BBC_POL_TX_EN_BIT];
      rx_active <= receive_enable_input;
      // select 00..03 picks the modulation and its code
      tx_mod_sel       <= sel_code;
      tx_mod_sel_valid <= sel_legal;
      tx_signal_code   <= regs_q[I_SF_BASE[4:0] + {3'h0, sel_code}];
      tx_service       <= regs_q[I_SERVICE[4:0]];
      // high byte first in the length word
      tx_length        <= {regs_q[I_LEN_HI[4:0]], regs_q[I_LEN_LO[4:0]]};
      io_polarity      <= regs_q[I_IO_POL[4:0]];
      tx_rx_control    <= regs_q[I_TXRX[4:0]];
      scrambler_taps   <= regs_q[I_SCRAM[4:0]];
      preamble_length  <= regs_q[I_PREAMBLE[4:0]];
      sfd_timer        <= regs_q[I_SFD[4:0]];
      test_bus_select  <= regs_q[I_TBUS_SEL[4:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // acquisition correlator

  // fed with raw samples, ahead of any carrier correction
  bbc_acq_corr #(
    .CHIPS (CORR_CHIPS)
  ) u_acq_corr (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample_valid (acq_sample_valid),
    .sample_sign  (acq_sample_sign),
    .match_q      (acq_match_count)
  );

endmodule // bbc_regs_top

// File: verification/bbc_regs_props.sv
// assertion checker for the baseband config register bank
`timescale 1ns/1ps
module bbc_regs_props (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        tx_active,
  input wire        rx_active,
  input wire [3:0]  acq_match_count,
  input wire [15:0] tx_length,
  input wire [7:0]  io_polarity
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc    = psel && penable;
  wire ctl_wr = acc && pwrite && paddr[7:2] == 6'h02;
  wire busy   = tx_active || rx_active;

  ////////////////////////////////////////////////////////////////////////
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access phase");
  a_err_unmapped: assert property (acc && paddr[7] |-> pslverr)
    else $error("no error on unmapped index");
  a_err_ctrl: assert property (ctl_wr && busy |-> pslverr)
    else $error("control write while active not refused");
  a_ok_noerr: assert property (
    acc && !paddr[7] && !(ctl_wr && busy) |-> !pslverr)
    else $error("error on legal access");
  a_rd_upper: assert property (prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_rd_unmapped: assert property (
    psel && !penable && !pwrite && paddr[7] |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_len_high: assert property (
    acc && pwrite && paddr[7:2] == 6'h16 |->
    ##2 tx_length[15:8] == $past(pwdata[7:0], 2))
    else $error("length high byte not applied");
  a_pol_write: assert property (
    acc && pwrite && paddr[7:2] == 6'h01 |->
    ##2 io_polarity == $past(pwdata[7:0], 2))
    else $error("polarity copy not applied");
  a_acq_range: assert property (acq_match_count <= 4'hb)
    else $error("match count above chip count");

  c_ctl_refused: cover property (ctl_wr && busy);
  c_unmapped:    cover property (acc && paddr[7]);
  c_len_write:   cover property (acc && pwrite && paddr[7:2] == 6'h17);
endmodule // bbc_regs_props

bind bbc_regs_top bbc_regs_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_active(tx_active),
  .rx_active(rx_active), .acq_match_count(acq_match_count),
  .tx_length(tx_length), .io_polarity(io_polarity)
);

// File: verification/bbc_apb_host.sv
// host controller model: APB master that programs the register bank
`timescale 1ns/1ps
module bbc_apb_host (
  input  wire        pclk,
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer; waits on pready, only the bench watchdog ends a hang
  task xfer(input w, input [7:0] a, input [31:0] d,
            output [31:0] q, output e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // bbc_apb_host

// File: verification/tb.sv
// self-checking bench of the register bank against a behavioural model
`timescale 1ns/1ps
`include "bbc_regs.vh"
module tb;
  localparam [7:0] PV = 8'h3c; // arbitrary identity value
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        tei = 1'b0, rei = 1'b0, hv = 1'b0, sv = 1'b0, ss = 1'b0;
  logic [7:0]  hs = 8'h0, hsv = 8'h0, hlh = 8'h0, hll = 8'h0, tb_obs = 8'h0;
  wire         psel, penable, pwrite, pready, pslverr, txa, rxa, msv;
  wire  [7:0]  paddr, sigc;
  wire  [31:0] pwdata, prdata;
  wire  [1:0]  msel;
  wire  [15:0] tlen;
  wire  [7:0]  tsv, pol, trc, stp, prl, sfd, tbs;
  wire  [3:0]  amc;
  logic [7:0]  m [0:31];
  logic [31:0] q;
  logic        e;
  integer      fail_count = 0, samples_checked = 0, seed = 51803, i;

  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    sv <= $random(seed);
    ss <= $random(seed);
  end

  bbc_apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  bbc_regs_top #(.PART_VERSION(PV)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_enable_input(tei), .receive_enable_input(rei),
    .rx_hdr_valid(hv), .rx_hdr_status(hs), .rx_hdr_service(hsv),
    .rx_hdr_len_high(hlh), .rx_hdr_len_low(hll),
    .test_bus_observe_in(tb_obs), .acq_sample_valid(sv),
    .acq_sample_sign(ss), .acq_match_count(amc), .tx_active(txa),
    .rx_active(rxa), .tx_mod_sel(msel), .tx_mod_sel_valid(msv),
    .tx_signal_code(sigc), .tx_service(tsv), .tx_length(tlen),
    .io_polarity(pol), .tx_rx_control(trc), .scrambler_taps(stp),
    .preamble_length(prl), .sfd_timer(sfd), .test_bus_select(tbs));

  task automatic chk(input [31:0] seen, input [31:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function bit ro(input integer k);
    return k == 0 || (k >= 24 && k <= 27) || k == 29;
  endfunction
  // correlator model: 22 sign stages, even stages compared with the code
  localparam [10:0] ACQ_CODE = 11'h5b8; // the correlator's default code
  logic [21:0] acq_sh = 22'h0;
  integer      acq_exp = 0;
  function automatic integer acq_count(input logic [21:0] s);
    integer n = 0;
    for (int j = 0; j < 11; j++)
      if (s[2*j] == ACQ_CODE[j]) n++;
    return n;
  endfunction
  // count lags the shift register by one edge
  always @(posedge pclk) begin
    if (!presetn) begin
      acq_sh = 22'h0;
      acq_exp = 0;
    end else begin
      chk(amc, acq_exp, "acq_match");
      acq_exp = acq_count(acq_sh);
      if (sv) acq_sh = {acq_sh[20:0], ss};
    end
  end
  // every register read back, with random ignored low address bits
  task read_all;
    for (i = 0; i < 32; i++) begin
      host.xfer(1'b0, {i[5:0], 2'($random(seed))}, 32'h0, q, e);
      chk(q, {24'h0, m[i]}, "read");
      chk(e, 1'b0, "rd_err");
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #(20 * 30000);
    fail_count++;
    final_report;
  end

  initial begin
    m = '{PV, `BBC_RST_IO_POL, `BBC_RST_TXRX_CTRL, `BBC_RST_CAL_POS,
      `BBC_RST_CAL_NEG, `BBC_RST_CCA_ANT, `BBC_RST_PREAMBLE,
      `BBC_RST_SCRAM_TAPS, `BBC_RST_SQ1_HI, `BBC_RST_SQ1_LO,
      `BBC_RST_SQ2_HI, `BBC_RST_SQ2_LO, `BBC_RST_CCA_HI, `BBC_RST_CCA_LO,
      `BBC_RST_ED_THRESH, `BBC_RST_SFD_TIMER, `BBC_RST_SF_BKR_BIN,
      `BBC_RST_SF_BKR_QUAD, `BBC_RST_SF_WAL_BIN, `BBC_RST_SF_WAL_QUAD,
      `BBC_RST_TX_SIG_SEL, `BBC_RST_TX_SERVICE, `BBC_RST_TX_LEN_HI,
      `BBC_RST_TX_LEN_LO, 8'h0, 8'h0, 8'h0, 8'h0, `BBC_RST_TBUS_SEL,
      8'h0, `BBC_RST_TEST1, `BBC_RST_TEST2};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // header capture plus live test bus, then defaults
    @(posedge pclk);
    {hs, hsv, hlh, hll, tb_obs} <= {$random(seed), 8'($random(seed))};
    hv <= 1'b1;
    @(posedge pclk);
    hv <= 1'b0;
    {m[24], m[25], m[26], m[27], m[29]} = {hs, hsv, hlh, hll, tb_obs};
    read_all;
    $display("test defaults done");
    // random writes everywhere; read-only places must not move
    for (integer k = 0; k < 32; k++) begin
      host.xfer(1'b1, {k[5:0], 2'($random(seed))}, $random(seed), q, e);
      chk(e, 1'b0, "wr_err");
      if (!ro(k)) m[k] = pwdata[7:0];
      // keep transmit idle under whatever polarity was just written
      if (k == 1) tei <= m[1][`BBC_POL_TX_EN_BIT];
    end
    read_all;
    chk(msel, m[20][1:0], "mod_sel_rand");
    chk(msv, m[20][7:2] == 6'h0, "mod_valid_rand");
    chk(sigc, m[16 + m[20][1:0]], "sig_code_rand");
    $display("test readback done");
    // modulation select: simplest differential binary first
    for (integer k = 0; k < 4; k++) begin
      host.xfer(1'b1, `BBC_OFF_TX_SIG_SEL, k, q, e);
      m[20] = k;
      repeat (2) @(posedge pclk);
      chk(msel, k[1:0], "mod_sel");
      chk(msv, 1'b1, "mod_valid");
      chk(sigc, m[16 + k], "sig_code");
      chk(tlen, {m[22], m[23]}, "tx_length");
      chk(tsv, m[21], "tx_service");
      chk(pol, m[1], "io_polarity");
      chk(trc, m[2], "tx_rx_control");
      chk(stp, m[7], "scrambler_taps");
      chk(prl, m[6], "preamble_length");
      chk(sfd, m[15], "sfd_timer");
      chk(tbs, m[28], "test_bus_select");
    end
    $display("test modulation done");
    // control write refused while transmit enable, then receive enable, is active
    tei <= ~m[1][`BBC_POL_TX_EN_BIT];
    repeat (3) @(posedge pclk);
    chk(txa, 1'b1, "tx_active");
    host.xfer(1'b1, `BBC_OFF_TXRX_CTRL, ~m[2], q, e);
    chk(e, 1'b1, "ctl_busy");
    tei <= m[1][`BBC_POL_TX_EN_BIT];
    rei <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(txa, 1'b0, "tx_idle");
    chk(rxa, 1'b1, "rx_active");
    host.xfer(1'b1, `BBC_OFF_TXRX_CTRL, ~m[2], q, e);
    chk(e, 1'b1, "ctl_rx_busy");
    rei <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(rxa, 1'b0, "rx_idle");
    host.xfer(1'b0, `BBC_OFF_TXRX_CTRL, 32'h0, q, e);
    chk(q, {24'h0, m[2]}, "ctl_kept");
    $display("test control guard done");
    // unmapped indices refused
    host.xfer(1'b1, 8'hfc, $random(seed), q, e);
    chk(e, 1'b1, "unmap_wr");
    host.xfer(1'b0, 8'h80 | 8'($random(seed)), 32'h0, q, e);
    chk(e, 1'b1, "unmap_rd");
    chk(q, 32'h0, "unmap_data");
    read_all;
    $display("test unmapped done");
    final_report;
  end
endmodule // tb
